/* File: cfg_fwd_consts.vh */
`ifndef CFG_FWD_CONSTS_VH
`define CFG_FWD_CONSTS_VH

// Bus commands carried on C/BE[3:0] during the address phase.
`define CMD_SPECIAL     4'h1
`define CMD_CFG_READ    4'hA
`define CMD_CFG_WRITE   4'hB

// Configuration address type codes in address bits 1:0.
`define CFG_TYPE0       2'h0
`define CFG_TYPE1       2'h1

// Field positions of a configuration address.
`define TYPE_HI         1
`define TYPE_LO         0
`define REG_HI          7
`define REG_LO          2
`define FUNC_HI         10
`define FUNC_LO         8
`define DEV_HI          15
`define DEV_LO          11
`define BUS_HI          23
`define BUS_LO          16
`define IDSEL_HI        31
`define IDSEL_LO        16

// Field values that select special cycles and on-chip IDSEL lines.
`define DEV_ALL_ONES    5'h1F
`define FUNC_ALL_ONES   3'h7
`define REG_ZERO        6'h00
`define DEV_IDSEL_MAX   5'h0F
`define DEV_ZERO        5'h00
`define IDSEL_NONE      16'h0000
`define IDSEL_ONE       16'h0001

// Read data returned when the target bus ended in master abort.
`define ABORT_RDATA     32'hFFFFFFFF
`define WORD_ZERO       32'h00000000

// Forwarding decisions.
`define ACT_NONE        3'h0
`define ACT_TYPE0       3'h1
`define ACT_T1_DOWN     3'h2
`define ACT_T1_UP       3'h3
`define ACT_SPC_DOWN    3'h4
`define ACT_SPC_UP      3'h5

`endif

/* File: cfg_decode.v */
`timescale 1ns/1ns
`default_nettype none
`include "cfg_fwd_consts.vh"

// Pure address-phase decode: which forwarding action applies and the
// address and command to be driven on the target bus.
module cfg_decode (
  input  wire        from_secondary, // Request was seen on the secondary bus
  input  wire [31:0] addr,           // Address-phase AD
  input  wire [3:0]  cmd,            // Address-phase command
  input  wire [7:0]  primary_bus,    // Primary bus number setting
  input  wire [7:0]  secondary_bus,  // Secondary bus number setting
  input  wire [7:0]  subordinate_bus,// Subordinate bus number setting
  output reg  [2:0]  action,         // Forwarding decision
  output reg  [31:0] fwd_addr,       // Address for the target bus
  output reg  [3:0]  fwd_cmd         // Command for the target bus
);

  function [15:0] idsel_of;
    input [4:0] dev;
    begin
      if (dev <= `DEV_IDSEL_MAX) begin
        idsel_of = `IDSEL_ONE << dev[3:0];
      end else begin
        idsel_of = `IDSEL_NONE;
      end
    end
  endfunction

  wire [1:0] typ   = addr[`TYPE_HI:`TYPE_LO];
  wire [5:0] regno = addr[`REG_HI:`REG_LO];
  wire [2:0] func  = addr[`FUNC_HI:`FUNC_LO];
  wire [4:0] dev   = addr[`DEV_HI:`DEV_LO];
  wire [7:0] bus   = addr[`BUS_HI:`BUS_LO];
  wire       is_cfg = (cmd == `CMD_CFG_READ) || (cmd == `CMD_CFG_WRITE);
  wire       is_wr  = (cmd == `CMD_CFG_WRITE);
  wire       spc_id = (dev == `DEV_ALL_ONES) && (func == `FUNC_ALL_ONES);
  wire       in_range_excl = (bus > secondary_bus) && (bus <= subordinate_bus);
  wire       in_range_incl = (bus >= secondary_bus) && (bus <= subordinate_bus);

  always @* begin
    action = `ACT_NONE;
    if (is_cfg && typ == `CFG_TYPE1) begin
      if (!from_secondary) begin
        if (bus == secondary_bus) begin
          if (is_wr && spc_id && regno == `REG_ZERO) begin
            action = `ACT_SPC_DOWN;
          end else begin
            action = `ACT_TYPE0;
          end
        end else if (in_range_excl) begin
          action = `ACT_T1_DOWN;
        end
      end else if (is_wr && spc_id) begin
        if (bus == primary_bus && regno == `REG_ZERO) begin
          action = `ACT_SPC_UP;
        end else if (!in_range_incl) begin
          action = `ACT_T1_UP;
        end
      end
    end
  end

  always @* begin
    fwd_addr = addr;
    fwd_cmd  = cmd;
    if (action == `ACT_TYPE0) begin
      // Type 0 is only ever built for the secondary bus.
      fwd_addr = {idsel_of(dev), `DEV_ZERO, addr[`FUNC_HI:`REG_LO],
                  `CFG_TYPE0};
    end else if (action == `ACT_SPC_DOWN || action == `ACT_SPC_UP) begin
      fwd_cmd = `CMD_SPECIAL;
    end
  end

endmodule
`default_nettype wire

/* File: config_cycle_forwarding.v */
`timescale 1ns/1ns
`default_nettype none
`include "cfg_fwd_consts.vh"

// Overview of operation
// - Type 0 only produced downstream, never primary.
// - Claim Type 1 for secondary bus number.
// - Translated address: type 00b, device field zero.
// - Devices 0-15 get one-hot IDSEL bit.
// - Devices 10h-1Eh: no IDSEL, still forwarded.
// - Device 1Fh: special cycle or no IDSEL.
// - No IDSEL response means master abort.
// - Translated accesses delayed, one 32-bit transfer.
// - Forward Type 1 downstream within bus range.
// - Forward special-cycle Type 1 writes upstream.
// - Type 1 writes delayed, single transfer.
// - Ignore special cycles seen as target.
// - Type 1 write to 1Fh/7, register 0, addressed to the target bus becomes special cycle.
// - Special cycle: command replaced, address/data kept.
// - Special cycle master abort then TRDY retry.
// - Multiple transfers requested: disconnect first phase.
// - Ignore Type 0 from secondary bus.
module config_cycle_forwarding (
  input  wire        sys_clk,          // Clock, 10 MHz
  input  wire        rstn,             // Synchronous reset, active low
  input  wire [7:0]  primary_bus,      // Primary bus number setting
  input  wire [7:0]  secondary_bus,    // Secondary bus number setting
  input  wire [7:0]  subordinate_bus,  // Subordinate bus number setting
  input  wire        req_valid,        // Address phase of an initiator attempt
  input  wire        req_from_secondary, // Attempt seen on the secondary bus
  input  wire [31:0] req_addr,         // Address-phase AD
  input  wire [3:0]  req_cmd,          // Address-phase command
  input  wire [31:0] req_wdata,        // First data phase write data
  input  wire        req_multi,        // Initiator wants more than one data phase
  output wire        resp_claim,       // Bridge claims the attempt (DEVSEL)
  output wire        resp_retry,       // Claimed attempt is retried
  output wire        resp_trdy,        // Claimed attempt completes one data phase
  output wire        resp_disconnect,  // Disconnect with the completing phase
  output reg  [31:0] resp_rdata,       // Read data for the completing phase
  output reg         resp_master_abort,// Target bus ended in master abort
  output reg         out_valid,        // Transaction pending on the target bus
  output reg         out_on_secondary, // Target bus is the secondary bus
  output reg  [31:0] out_addr,         // Address for the target bus
  output reg  [3:0]  out_cmd,          // Command for the target bus
  output reg  [31:0] out_wdata,        // Write data for the target bus
  input  wire        out_done,         // Target bus transaction finished
  input  wire        out_master_abort, // Finished by master abort
  input  wire [31:0] out_rdata         // Read data from the target bus
);

  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_ISSUE = 2'h1;
  localparam [1:0] ST_CPL   = 2'h2;

  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg         held_from_secondary;
  reg  [31:0] held_addr;
  reg  [3:0]  held_cmd;
  reg  [31:0] held_wdata;
  reg  [2:0]  held_action;

  wire [2:0]  dec_action;
  wire [31:0] dec_addr;
  wire [3:0]  dec_cmd;

  cfg_decode u_decode (
    .from_secondary  (req_from_secondary),
    .addr            (req_addr),
    .cmd             (req_cmd),
    .primary_bus     (primary_bus),
    .secondary_bus   (secondary_bus),
    .subordinate_bus (subordinate_bus),
    .action          (dec_action),
    .fwd_addr        (dec_addr),
    .fwd_cmd         (dec_cmd)
  );

  function is_special;
    input [2:0] act;
    begin
      is_special = (act == `ACT_SPC_DOWN) || (act == `ACT_SPC_UP);
    end
  endfunction

  // A repeat must match direction, address and command; writes also data.
  wire same_req = (req_from_secondary == held_from_secondary) &&
                  (req_addr == held_addr) && (req_cmd == held_cmd) &&
                  ((req_cmd != `CMD_CFG_WRITE) || (req_wdata == held_wdata));

  wire target_side_secondary = !req_from_secondary;

  assign resp_claim      = req_valid && (dec_action != `ACT_NONE);
  // Only one delayed entry exists: every claimed attempt is retried until
  // its own completion is waiting, which limits throughput but not order.
  assign resp_trdy       = resp_claim && (state == ST_CPL) && same_req;
  assign resp_retry      = resp_claim && !resp_trdy;
  assign resp_disconnect = resp_trdy && req_multi;

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (resp_claim) begin
          next_state = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        if (out_done) begin
          next_state = ST_CPL;
        end
      end
      ST_CPL: begin
        if (resp_trdy) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Next values of the entry, the target-bus request and the completion.
  reg         next_held_from_secondary;
  reg  [31:0] next_held_addr;
  reg  [3:0]  next_held_cmd;
  reg  [31:0] next_held_wdata;
  reg  [2:0]  next_held_action;
  reg         next_out_valid;
  reg         next_out_on_secondary;
  reg  [31:0] next_out_addr;
  reg  [3:0]  next_out_cmd;
  reg  [31:0] next_out_wdata;
  reg  [31:0] next_resp_rdata;
  reg         next_resp_master_abort;

  wire        in_idle    = (state == ST_IDLE);
  wire        in_issue   = (state == ST_ISSUE);
  wire        take_entry = in_idle && resp_claim;
  wire        target_end = in_issue && out_done;

  // The entry is written only from idle, so a retried attempt for some
  // other target can never overwrite the one that is in flight.
  always @* begin
    next_held_from_secondary = held_from_secondary;
    next_held_addr           = held_addr;
    next_held_cmd            = held_cmd;
    next_held_wdata          = held_wdata;
    next_held_action         = held_action;
    if (take_entry) begin
      next_held_from_secondary = req_from_secondary;
      next_held_addr           = req_addr;
      next_held_cmd            = req_cmd;
      next_held_wdata          = req_wdata;
      next_held_action         = dec_action;
    end
  end

  always @* begin
    next_out_valid        = out_valid;
    next_out_on_secondary = out_on_secondary;
    next_out_addr         = out_addr;
    next_out_cmd          = out_cmd;
    next_out_wdata        = out_wdata;
    if (take_entry) begin
      next_out_valid        = 1'h1;
      next_out_on_secondary = target_side_secondary;
      next_out_addr         = dec_addr;
      next_out_cmd          = dec_cmd;
      next_out_wdata        = req_wdata;
    end else if (target_end) begin
      next_out_valid        = 1'h0;
    end
  end

  always @* begin
    next_resp_rdata        = resp_rdata;
    next_resp_master_abort = resp_master_abort;
    if (take_entry) begin
      next_resp_master_abort = 1'h0;
    end else if (target_end) begin
      if (is_special(held_action)) begin
        // Special cycles always end in master abort; that is success.
        next_resp_master_abort = 1'h0;
        next_resp_rdata        = `WORD_ZERO;
      end else if (out_master_abort) begin
        next_resp_master_abort = 1'h1;
        next_resp_rdata        = `ABORT_RDATA;
      end else begin
        next_resp_master_abort = 1'h0;
        next_resp_rdata        = out_rdata;
      end
    end
  end

  // Each register has its own process, so its reset value sits right
  // beside the value it takes in normal operation.
  always @(posedge sys_clk) begin
    if (!rstn) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always @(posedge sys_clk) begin
    if (!rstn) begin
      held_from_secondary <= 1'h0;
    end else begin
      held_from_secondary <= next_held_from_secondary;
    end
  end

  always @(posedge sys_clk) begin
    if (!rstn) begin
      held_addr <= `WORD_ZERO;
    end else begin
      held_addr <= next_held_addr;
    end
  end

  always @(posedge sys_clk) begin
    if (!rstn) begin
      held_cmd <= `CMD_CFG_READ;
    end else begin
      held_cmd <= next_held_cmd;
    end
  end

  always @(posedge sys_clk) begin
    if (!rstn) begin
      held_wdata <= `WORD_ZERO;
    end else begin
      held_wdata <= next_held_wdata;
    end
  end

  always @(posedge sys_clk) begin
    if (!rstn) begin
      held_action <= `ACT_NONE;
    end else begin
      held_action <= next_held_action;
    end
  end

  always @(posedge sys_clk) begin
    if (!rstn) begin
      out_valid <= 1'h0;
    end else begin
      out_valid <= next_out_valid;
    end
  end

  always @(posedge sys_clk) begin
    if (!rstn) begin
      out_on_secondary <= 1'h0;
    end else begin
      out_on_secondary <= next_out_on_secondary;
    end
  end

  always @(posedge sys_clk) begin
    if (!rstn) begin
      out_addr <= `WORD_ZERO;
    end else begin
      out_addr <= next_out_addr;
    end
  end

  always @(posedge sys_clk) begin
    if (!rstn) begin
      out_cmd <= `CMD_CFG_READ;
    end else begin
      out_cmd <= next_out_cmd;
    end
  end

  always @(posedge sys_clk) begin
    if (!rstn) begin
      out_wdata <= `WORD_ZERO;
    end else begin
      out_wdata <= next_out_wdata;
    end
  end

  always @(posedge sys_clk) begin
    if (!rstn) begin
      resp_rdata <= `WORD_ZERO;
    end else begin
      resp_rdata <= next_resp_rdata;
    end
  end

  always @(posedge sys_clk) begin
    if (!rstn) begin
      resp_master_abort <= 1'h0;
    end else begin
      resp_master_abort <= next_resp_master_abort;
    end
  end

endmodule
`default_nettype wire

/* File: cfg_fwd_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module cfg_fwd_assertions (
  input wire logic        sys_clk, rstn, req_valid, req_from_secondary, req_multi,
  input wire logic        resp_claim, resp_retry, resp_trdy, resp_disconnect,
  input wire logic        resp_master_abort, out_valid, out_on_secondary,
  input wire logic        out_done, out_master_abort,
  input wire logic [7:0]  secondary_bus, subordinate_bus,
  input wire logic [31:0] req_addr, req_wdata, resp_rdata, out_addr, out_wdata,
  input wire logic [3:0]  req_cmd, out_cmd
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic [31:0] last_addr;
  logic [31:0] last_wdata;
  logic [3:0]  last_cmd;
  wire logic   t1 = req_cmd[3:1] == 3'h5 && req_addr[1:0] == 2'h1;
  wire logic   nb = req_addr[23:16] > secondary_bus && req_addr[23:16] <= subordinate_bus;
  // The captured request is compared one cycle later, after it has left the request pins.
  always @(posedge sys_clk) begin
    last_addr <= req_addr;
    last_wdata <= req_wdata;
    last_cmd <= req_cmd;
  end
  sequence s_cap;
    req_valid && resp_retry ##1 $rose(out_valid);
  endsequence
  property p_no_t0_pri;
    out_valid && !out_on_secondary && out_cmd[3:1] == 3'h5 |-> out_addr[1:0] == 2'h1;
  endproperty
  a_no_t0_pri: assert property (p_no_t0_pri) else $error("type 0 on primary");
  property p_claim;
    req_valid && !req_from_secondary && t1 && req_addr[23:16] == secondary_bus |-> resp_claim;
  endproperty
  a_claim: assert property (p_claim) else $error("translation not claimed");
  property p_idsel;
    s_cap ##0 out_addr[1:0] == 2'h0 |-> out_on_secondary && out_addr[15:11] == 5'h00
      && out_addr[10:2] == last_addr[10:2] && out_addr[31:16] ==
      (last_addr[15] ? 16'h0000 : 16'h0001 << last_addr[14:11]);
  endproperty
  a_idsel: assert property (p_idsel) else $error("bad translated address");
  property p_down;
    (req_valid && resp_retry && !req_from_secondary && t1 && nb) ##1 $rose(out_valid)
      |-> out_on_secondary && out_addr == last_addr;
  endproperty
  a_down: assert property (p_down) else $error("bad downstream type 1");
  property p_up;
    (req_valid && resp_retry && req_from_secondary) ##1 $rose(out_valid) |-> !out_on_secondary;
  endproperty
  a_up: assert property (p_up) else $error("upstream on wrong bus");
  property p_spc;
    s_cap ##0 out_cmd == 4'h1 |-> out_addr == last_addr && out_wdata == last_wdata
      && last_cmd == 4'hB;
  endproperty
  a_spc: assert property (p_spc) else $error("special cycle altered");
  property p_no_spc;
    req_valid && req_cmd == 4'h1 |-> !resp_claim;
  endproperty
  a_no_spc: assert property (p_no_spc) else $error("special cycle claimed");
  property p_no_t0_sec;
    req_valid && req_from_secondary && req_addr[1:0] == 2'h0 |-> !resp_claim;
  endproperty
  a_no_t0_sec: assert property (p_no_t0_sec) else $error("secondary type 0 claimed");
  property p_disc;
    req_valid && resp_claim && !resp_retry |-> resp_trdy && !out_valid
      && resp_disconnect == req_multi;
  endproperty
  a_disc: assert property (p_disc) else $error("bad disconnect");
  property p_hold;
    out_valid && !out_done |=> out_valid && $stable(out_addr);
  endproperty
  a_hold: assert property (p_hold) else $error("target request dropped");
  property p_abort;
    out_valid && out_done && out_master_abort && out_cmd != 4'h1
      |=> !out_valid && resp_master_abort && resp_rdata == 32'hFFFFFFFF;
  endproperty
  a_abort: assert property (p_abort) else $error("master abort lost");
  property p_spc_done;
    out_valid && out_done && out_cmd == 4'h1 |=> !out_valid && !resp_master_abort;
  endproperty
  a_spc_done: assert property (p_spc_done) else $error("special abort returned");
endmodule
bind config_cycle_forwarding cfg_fwd_assertions u_cfg_fwd_assertions (.*);
`default_nettype wire

/* File: cfg_target_model.sv */
`timescale 1ns/1ns
`default_nettype none
module cfg_target_model (
  input  wire logic        sys_clk,          // Clock
  input  wire logic        out_valid,        // Pending target transaction
  input  wire logic        out_on_secondary, // Runs on secondary bus
  input  wire logic [31:0] out_addr,         // Target address
  input  wire logic [3:0]  out_cmd,          // Target command
  input  wire logic [3:0]  dly,              // Cycles before finishing
  output var  logic        out_done,         // Finish pulse
  output wire logic        out_master_abort, // Nobody answered
  output wire logic [31:0] out_rdata         // Read data
);
  logic [3:0] cnt = 4'h0;
  // Special cycles and type 0 with no select line find no target.
  wire logic none = out_cmd == 4'h1 || out_on_secondary && out_addr[1:0] == 2'h0
                    && out_addr[31:16] == 16'h0000;
  initial out_done = 1'b0;
  always @(posedge sys_clk) begin
    cnt <= out_valid && !out_done ? cnt + 4'h1 : 4'h0;
    out_done <= out_valid && !out_done && cnt == dly;
  end
  assign out_master_abort = out_done && none;
  // Outside the answer the data lines wander so a stale value is never trusted.
  assign out_rdata = out_done && !none ? out_addr ^ 32'h0F0F0F0F : {8{cnt}};
endmodule
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        req_valid = 1'b0;
  logic        req_from_secondary = 1'b0;
  logic        req_multi = 1'b0;
  logic [31:0] req_addr = 32'h0, req_wdata = 32'h0;
  logic [3:0]  req_cmd = 4'h0, dly = 4'h0, rsp;
  logic [7:0]  primary_bus = 8'h01, secondary_bus = 8'h02, subordinate_bus = 8'h05;
  wire logic   resp_claim, resp_retry, resp_trdy, resp_disconnect, resp_master_abort;
  wire logic   out_valid, out_on_secondary, out_done, out_master_abort;
  wire logic [31:0] resp_rdata, out_addr, out_wdata, out_rdata;
  wire logic [3:0]  out_cmd;
  integer      n_fail = 0, tests_run = 0;
  config_cycle_forwarding u_config_cycle_forwarding (.*);
  cfg_target_model u_cfg_target_model (.*);
  always #50 sys_clk = ~sys_clk;
  task close_out;
    begin
      $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      tests_run++;
      if (got !== exp) begin
        $display("Error at %0t: got %h expected %h", $time, got, exp);
        n_fail++;
      end
    end
  endtask
  task att(input logic s, input logic [31:0] a, input logic [3:0] c, input logic m);
    begin
      @(negedge sys_clk);
      req_valid = 1'b1;
      req_from_secondary = s;
      req_addr = a;
      req_cmd = c;
      req_wdata = ~a;
      req_multi = m;
      #10 rsp = {resp_claim, resp_retry, resp_trdy, resp_disconnect};
      @(negedge sys_clk) req_valid = 1'b0;
    end
  endtask
  // First attempt is retried, the repeat after the target finishes completes.
  task run(input logic s, input logic [31:0] a, input logic [3:0] c, input logic m,
           input logic es, input logic [31:0] ea, input logic [3:0] ec, input logic [31:0] er);
    integer k;
    begin
      att(s, a, c, m);
      chk(rsp, 4'hC);
      chk({out_on_secondary, out_cmd}, {es, ec});
      chk(out_addr, ea);
      if (c == 4'hB) chk(out_wdata, ~a);
      k = 0;
      while (out_valid && k < 99) begin
        @(negedge sys_clk);
        k++;
      end
      att(s, a, c, m);
      chk(rsp, {3'h5, m});
      if (c == 4'hA) chk(resp_rdata, er);
    end
  endtask
  task t_type0;
    logic [31:0] a, ea, r;
    begin
      for (int d = 0; d < 32; d++) begin
        dly = d[0] ? 4'h9 : 4'h0;
        a = {16'h0002, d[4:0], 3'h5, 6'h0C, 2'h1};
        ea = {(d < 16 ? 16'h0001 << d : 16'h0000), 5'h00, a[10:2], 2'h0};
        r = d < 16 ? ea ^ 32'h0F0F0F0F : 32'hFFFFFFFF;
        run(1'b0, a, 4'hA, 1'b0, 1'b1, ea, 4'hA, r);
        chk(resp_master_abort, d > 15);
      end
      $display("type 0 translation done");
    end
  endtask
  task t_t1;
    begin
      run(1'b0, 32'h00030A05, 4'hA, 1'b0, 1'b1, 32'h00030A05, 4'hA, 32'h0F0C050A);
      run(1'b0, 32'h0005F80D, 4'hB, 1'b1, 1'b1, 32'h0005F80D, 4'hB, 32'h0);
      run(1'b1, 32'h0009FF09, 4'hB, 1'b0, 1'b0, 32'h0009FF09, 4'hB, 32'h0);
      $display("type 1 forwarding done");
    end
  endtask
  task t_spc;
    begin
      run(1'b0, 32'h0002FF01, 4'hB, 1'b1, 1'b1, 32'h0002FF01, 4'h1, 32'h0);
      chk(resp_master_abort, 1'b0);
      run(1'b1, 32'h0001FF01, 4'hB, 1'b0, 1'b0, 32'h0001FF01, 4'h1, 32'h0);
      chk(resp_master_abort, 1'b0);
      $display("special cycles done");
    end
  endtask
  task t_refuse;
    begin
      att(1'b0, 32'h0002FF01, 4'h1, 1'b0);
      chk({rsp, out_valid}, 5'h00);
      att(1'b1, 32'h00000A00, 4'hA, 1'b0);
      chk({rsp, out_valid}, 5'h00);
      att(1'b0, 32'h00090A05, 4'hA, 1'b0);
      chk({rsp, out_valid}, 5'h00);
      att(1'b1, 32'h0009FF09, 4'hA, 1'b0);
      chk({rsp, out_valid}, 5'h00);
      $display("refusals done");
    end
  endtask
  initial begin
    repeat (20) @(negedge sys_clk);
    rstn = 1'b1;
    t_type0;
    t_t1;
    t_spc;
    t_refuse;
    close_out;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    close_out;
  end
endmodule
`default_nettype wire
